// ==== sms_cfg.svh ====
// constants of the snapshot mode sequencer
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH
`define SMS_POS_W   32
`define SMS_DEPTH   16
`define SMS_IDX_W   4
`define SMS_AN_W    12
`define SMS_MODE_W  4
`define SMS_DLY_W   32
`define SMS_INJ_W   3
`define SMS_MODE_RST 4'h0
`define SMS_MODE_MAX 4'hc
`define SMS_M_CAPKEY   4'h0
`define SMS_M_STEP     4'h1
`define SMS_M_EXT      4'h2
`define SMS_M_PATH     4'h3
`define SMS_M_CAPSNAP  4'h4
`define SMS_M_STEPSNAP 4'h5
`define SMS_M_TRIG     4'h6
`define SMS_M_AUTO     4'h7
`define SMS_M_CAPTRIG  4'h8
`define SMS_M_JUMP     4'h9
`define SMS_M_JUMPSNAP 4'ha
`define SMS_M_FOLZ     4'hb
`define SMS_M_FOLA     4'hc
`define SMS_K_BACK   0
`define SMS_K_PRIM   1
`define SMS_K_THIRD  2
`define SMS_K_FOURTH 3
`define SMS_INJ_MIN  3'h1
`define SMS_INJ_MAX  3'h4
`endif

// ==== sms_pkg.sv ====
// types of the snapshot mode sequencer
`include "sms_cfg.svh"
package sms_pkg;
  typedef logic signed [`SMS_POS_W-1:0] sms_pos_t;
  // one position per axis
  typedef struct packed {
    sms_pos_t x;
    sms_pos_t y;
    sms_pos_t z;
    sms_pos_t a;
  } sms_axes_t;
  // list entry: axes that travel plus positions
  typedef struct packed {
    logic [3:0] mask;
    sms_axes_t  pos;
  } sms_entry_t;
  typedef enum logic [1:0] {SMS_VEL_PRIMARY, SMS_VEL_SECONDARY, SMS_VEL_PATH} sms_vel_t;
  // command to the axis planners
  typedef struct packed {
    logic       valid;
    logic       rel;
    sms_vel_t   vel;
    logic [3:0] mask;
    sms_axes_t  pos;
  } sms_move_t;
  // qualified input events, one cycle each
  typedef struct packed {
    logic [3:0] key;
    logic       snap;
    logic       trig;
  } sms_evt_t;
  typedef enum logic [2:0] {SMS_IDLE, SMS_READ, SMS_LOAD, SMS_WAIT, SMS_DELAY} sms_state_t;
  typedef enum logic [2:0] {SMS_NX_NONE, SMS_NX_HOME, SMS_NX_FIRST, SMS_NX_PATH,
                            SMS_NX_AUTO} sms_next_t;
  // all control state of the sequencer
  typedef struct packed {
    sms_state_t             st;
    sms_next_t              after;
    sms_vel_t               vel;
    logic [`SMS_IDX_W-1:0]  idx;
    logic [`SMS_IDX_W-1:0]  raddr;
    logic [`SMS_IDX_W-1:0]  rd_prev;
    sms_move_t              mv;
    logic [3:0]             keyl;
    logic                   armed;
    logic                   arm_pend;
    logic                   paused;
    logic                   back;
    logic [`SMS_DLY_W-1:0]  dcnt;
    logic                   pending;
    logic [3:0]             hold;
    logic                   release_p;
    logic [`SMS_MODE_W-1:0] mode;
    logic                   mode_err;
    logic                   en_prev;
    logic [`SMS_IDX_W:0]    count;
    logic [`SMS_AN_W-1:0]   analog;
    logic                   busy;
    sms_entry_t             best;
    sms_pos_t               follow;
    logic                   follow_vld;
  } sms_ctl_t;
endpackage : sms_pkg

// ==== sms_list_mem.sv ====
// position list storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module sms_list_mem
  import sms_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  ce,
  input  wire logic                  wr,
  input  wire logic [`SMS_IDX_W-1:0] waddr,
  input  wire sms_entry_t            wdata,
  input  wire logic [`SMS_IDX_W-1:0] raddr,
  output var  sms_entry_t            rdata
);
  // ==========================================================
  // storage
  sms_entry_t mem [`SMS_DEPTH];  // list entries, no reset
  // write port and registered read port
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule : sms_list_mem
`default_nettype wire

// ==== sms_evt_in.sv ====
// qualification of key, inject and snapshot input events
`timescale 1ns/100ps
`default_nettype none
module sms_evt_in
  import sms_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  input  wire logic                  global_enable,
  input  wire logic                  input_polarity_select,
  input  wire logic                  snap_in,
  input  wire logic [3:0]            keys,
  input  wire logic                  inject_valid,
  input  wire logic [`SMS_INJ_W-1:0] inject_value,
  input  wire logic                  trigger_out_evt,
  output var  sms_evt_t              evt
);
  // ==========================================================
  // edge detection state
  logic     snap_prev;       // last snapshot level
  logic     primed;          // prev level valid after reset
  logic     next_snap_prev;
  logic     next_primed;
  sms_evt_t next_evt;
  logic     edge_hit;        // polarity matched edge
  logic [3:0] inj;           // injected key as one-hot
  // next values
  always_comb begin
    next_snap_prev = snap_in;
    next_primed    = 1'b1;
    edge_hit = primed && (input_polarity_select ? (snap_in && !snap_prev)
                                                : (!snap_in && snap_prev));  // R24
    inj = 4'h0;
    if (inject_valid && inject_value >= `SMS_INJ_MIN && inject_value <= `SMS_INJ_MAX) begin
      inj = 4'h1 << (inject_value - `SMS_INJ_MIN);  // R15
    end
    next_evt.key  = keys | inj;  // R15
    next_evt.snap = edge_hit;
    next_evt.trig = trigger_out_evt;
    if (!global_enable) begin
      next_evt = '0;  // R23
    end
  end
  // registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      snap_prev <= 1'b0;
      primed    <= 1'b0;
      evt       <= '0;
    end else if (ce) begin
      snap_prev <= next_snap_prev;
      primed    <= next_primed;
      evt       <= next_evt;
    end
  end
endmodule : sms_evt_in
`default_nettype wire

// ==== sms_sequencer.sv ====
// snapshot mode sequencer top: modes, captures, list moves, follow
// What this block does
// (R1) mode register readable, writable, resets to zero
// (R2) mode 0: primary key captures positions
// (R3) mode 1: primary key steps forward, wrapping
// (R4) mode 2: back/forward steps, approach sequences
// (R5) mode 3: path run, primary key, handheld enabled
// (R6) mode 4: snapshot input triggers capture
// (R7) mode 5: snapshot input steps forward
// (R8) mode 6: commands wait for snapshot event
// (R9) mode 7: home, auto stepping with delay
// (R10) mode 8: trigger-out captures positions and analog
// (R11) mode 9: keys jump relative forward/back
// (R12) mode 10: snapshot input jumps forward
// (R13) mode 11: Z target follows X list
// (R14) mode 12: A target follows X list
// (R15) inject values 1-4 act as keys
// (R16) captures sample analog, value readable
// (R17) capture all active axes; entry masks travel
// (R18) mode write clears latched keys, trigger wait
// (R19) waypoint moves always use secondary velocity
// (R20) reach waypoint before home or first
// (R21) mode 2 steps need arming by third key
// (R22) mode 7 key functions: home, start, pause, back
// (R23) events need global enable; toggle clears
// (R24) snapshot edge chosen by polarity select
// (R25) out-of-range mode write rejected, error flagged
`timescale 1ns/100ps
`default_nettype none
module sms_sequencer
  import sms_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   ce,
  input  wire logic                   mode_wr,
  input  wire logic [`SMS_MODE_W-1:0] mode_wdata,
  input  wire logic                   global_enable,
  input  wire logic                   input_polarity_select,
  input  wire logic                   snap_in,
  input  wire logic [3:0]             keys,
  input  wire logic                   inject_valid,
  input  wire logic [`SMS_INJ_W-1:0]  inject_value,
  input  wire logic                   trigger_out_evt,
  input  wire logic                   handheld_enable,
  input  wire logic                   cmd_req,
  input  wire logic [3:0]             trigger_axis_assign,
  input  wire logic [3:0]             active_axes,
  input  wire sms_axes_t              cur_pos,
  input  wire logic [`SMS_AN_W-1:0]   aux_analog_input,
  input  wire sms_axes_t              approach_waypoint,
  input  wire sms_axes_t              home_pos,
  input  wire sms_axes_t              jump_distance,
  input  wire logic [`SMS_DLY_W-1:0]  delay_cycles,
  input  wire logic                   motion_done,
  input  wire logic                   list_wr,
  input  wire logic [`SMS_IDX_W-1:0]  list_widx,
  input  wire sms_entry_t             list_wdata,
  input  wire logic                   list_clear,
  output var  logic [`SMS_MODE_W-1:0] mode,
  output var  logic                   mode_err,
  output var  sms_move_t              move,
  output var  logic [`SMS_AN_W-1:0]   analog_capture,
  output var  logic [`SMS_IDX_W:0]    list_count,
  output var  logic [3:0]             hold_axes,
  output var  logic                   release_pulse,
  output var  sms_pos_t               follow_pos,
  output var  logic                   follow_valid,
  output var  logic                   busy
);
  // ==========================================================
  // helpers
  // forward index with wrap at list end
  function automatic logic [`SMS_IDX_W-1:0] wrap_fwd(input logic [`SMS_IDX_W-1:0] i,
                                                     input logic [`SMS_IDX_W:0]   n);
    if ({1'b0, i} + 5'h01 >= n) begin
      wrap_fwd = '0;
    end else begin
      wrap_fwd = i + 4'h1;
    end
  endfunction : wrap_fwd
  // backward index with wrap at list start
  function automatic logic [`SMS_IDX_W-1:0] wrap_back(input logic [`SMS_IDX_W-1:0] i,
                                                      input logic [`SMS_IDX_W:0]   n);
    logic [`SMS_IDX_W:0] last;
    last = (n == 5'h00) ? 5'h00 : n - 5'h01;
    if (i == 4'h0 || {1'b0, i} > last) begin
      wrap_back = last[`SMS_IDX_W-1:0];
    end else begin
      wrap_back = i - 4'h1;
    end
  endfunction : wrap_back
  // modes whose keys start list or jump sequences
  function automatic logic is_move_mode(input logic [`SMS_MODE_W-1:0] m);
    is_move_mode = (m == `SMS_M_STEP) || (m == `SMS_M_EXT) || (m == `SMS_M_PATH) ||
                   (m == `SMS_M_STEPSNAP) || (m == `SMS_M_AUTO) ||
                   (m == `SMS_M_JUMP) || (m == `SMS_M_JUMPSNAP);
  endfunction : is_move_mode
  // ==========================================================
  // submodules
  sms_evt_t   evt;      // qualified events
  sms_entry_t rdata;    // list read data
  logic       w_en;     // list write strobe
  logic [`SMS_IDX_W-1:0] w_addr;  // list write index
  sms_entry_t w_data;   // list write entry
  sms_ctl_t   r;        // control state
  sms_ctl_t   n;        // next control state
  sms_evt_in u_evt (
    .clk                   (clk),
    .arst_n                (arst_n),
    .ce                    (ce),
    .global_enable         (global_enable),
    .input_polarity_select (input_polarity_select),
    .snap_in               (snap_in),
    .keys                  (keys),
    .inject_valid          (inject_valid),
    .inject_value          (inject_value),
    .trigger_out_evt       (trigger_out_evt),
    .evt                   (evt)
  );
  sms_list_mem u_mem (
    .clk   (clk),
    .ce    (ce),
    .wr    (w_en),
    .waddr (w_addr),
    .wdata (w_data),
    .raddr (r.raddr),
    .rdata (rdata)
  );
  // ==========================================================
  // next state
  logic [3:0] kin;   // keys after mode routing
  logic       clr;   // clear latched keys and trigger wait
  logic       cap;   // capture request
  logic       is_fol; // follow mode active
  always_comb begin
    n = r;
    n.mv.valid   = 1'b0;
    n.release_p  = 1'b0;
    n.en_prev    = global_enable;
    n.rd_prev    = r.raddr;
    w_en   = 1'b0;
    w_addr = r.count[`SMS_IDX_W-1:0];
    w_data = '0;
    kin    = evt.key;
    clr    = (global_enable != r.en_prev);  // R23
    is_fol = (r.mode == `SMS_M_FOLZ) || (r.mode == `SMS_M_FOLA);
    // mode write, accepted or rejected
    if (mode_wr) begin
      clr = 1'b1;  // R18
      if (mode_wdata > `SMS_MODE_MAX) begin
        n.mode_err = 1'b1;  // R25
      end else begin
        n.mode     = mode_wdata;  // R1
        n.mode_err = 1'b0;
        n.st       = SMS_IDLE;
        n.armed    = 1'b0;
        n.arm_pend = 1'b0;
        n.paused   = 1'b0;
        n.back     = 1'b0;
      end
    end
    // snapshot input replaces primary key in some modes
    if (r.mode == `SMS_M_STEPSNAP || r.mode == `SMS_M_JUMPSNAP) begin
      kin[`SMS_K_PRIM] = evt.snap;  // R7 R12
    end else if (r.mode == `SMS_M_CAPSNAP) begin
      kin[`SMS_K_PRIM] = 1'b0;
    end
    // pause keys of mode 7 act at once, not latched
    if (r.mode == `SMS_M_AUTO) begin
      if (kin[`SMS_K_THIRD]) begin
        n.paused = !r.paused;  // R22
      end
      if (kin[`SMS_K_FOURTH]) begin
        n.paused = 1'b1;  // R22
        n.back   = 1'b1;
      end
      kin[`SMS_K_THIRD]  = 1'b0;
      kin[`SMS_K_FOURTH] = 1'b0;
    end
    // latch keys for sequencer modes
    if (clr) begin
      n.keyl    = 4'h0;  // R18 R23
      n.pending = 1'b0;
    end else if (is_move_mode(r.mode)) begin
      n.keyl = r.keyl | kin;
    end
    // captures of modes 0, 4 and 8
    cap = ((r.mode == `SMS_M_CAPKEY) && kin[`SMS_K_PRIM]) ||  // R2
          ((r.mode == `SMS_M_CAPSNAP) && evt.snap) ||         // R6
          ((r.mode == `SMS_M_CAPTRIG) && evt.trig);           // R10
    if (cap && r.count < `SMS_DEPTH) begin
      w_en    = 1'b1;
      w_data  = {active_axes, cur_pos};  // R17
      n.count = r.count + 5'h01;
      n.analog = aux_analog_input;  // R16
    end else if (list_wr) begin
      w_en   = 1'b1;
      w_addr = list_widx;
      w_data = list_wdata;  // R17
      if ({1'b0, list_widx} >= r.count) begin
        n.count = {1'b0, list_widx} + 5'h01;
      end
    end
    if (list_clear) begin
      n.count = '0;
    end
    // triggered start of mode 6
    if (r.mode == `SMS_M_TRIG && !clr) begin
      if (evt.snap && r.pending) begin
        n.pending   = 1'b0;  // R8
        n.release_p = 1'b1;
      end
      if (cmd_req && global_enable) begin
        n.pending = 1'b1;  // R8
      end
    end
    // follow modes scan the list for the last X not above current X
    n.follow_vld = 1'b0;
    if (is_fol) begin
      n.raddr = wrap_fwd(r.raddr, r.count);
      if (r.count != 5'h00) begin
        n.follow_vld = r.follow_vld;
        if (r.rd_prev == 4'h0) begin
          n.follow     = (r.mode == `SMS_M_FOLZ) ? r.best.pos.z : r.best.pos.a;  // R13 R14
          n.follow_vld = 1'b1;
          n.best       = rdata;
        end else if (rdata.pos.x <= cur_pos.x) begin
          n.best = rdata;  // R13 R14
        end
      end
    end
    // sequencer
    case (r.st)
      SMS_IDLE: begin
        if (r.keyl[`SMS_K_BACK]) begin
          n.keyl[`SMS_K_BACK] = 1'b0;
          if (r.mode == `SMS_M_EXT && r.armed && r.count != 5'h00) begin
            n.idx = wrap_back(r.idx, r.count);  // R4 R21
            n.raddr = n.idx;
            n.vel = SMS_VEL_PRIMARY;
            n.after = SMS_NX_NONE;
            n.st = SMS_READ;
          end else if (r.mode == `SMS_M_JUMP || r.mode == `SMS_M_JUMPSNAP) begin
            n.mv = {1'b1, 1'b1, SMS_VEL_PRIMARY, active_axes,
                    -jump_distance.x, -jump_distance.y,
                    -jump_distance.z, -jump_distance.a};  // R11
          end
        end else if (r.keyl[`SMS_K_PRIM]) begin
          n.keyl[`SMS_K_PRIM] = 1'b0;
          if ((r.mode == `SMS_M_STEP || r.mode == `SMS_M_STEPSNAP ||
               (r.mode == `SMS_M_EXT && r.armed)) && r.count != 5'h00) begin
            n.idx = wrap_fwd(r.idx, r.count);  // R3 R4 R7 R21
            n.raddr = n.idx;
            n.vel = SMS_VEL_PRIMARY;
            n.after = SMS_NX_NONE;
            n.st = SMS_READ;
          end else if (r.mode == `SMS_M_PATH && handheld_enable && r.count != 5'h00) begin
            n.idx = 4'h0;  // R5
            n.raddr = 4'h0;
            n.vel = SMS_VEL_PATH;
            n.after = SMS_NX_PATH;
            n.st = SMS_READ;
          end else if (r.mode == `SMS_M_AUTO && r.count != 5'h00) begin
            n.idx = 4'h0;  // R9 R22
            n.raddr = 4'h0;
            n.vel = SMS_VEL_PRIMARY;
            n.after = SMS_NX_AUTO;
            n.paused = 1'b0;
            n.back = 1'b0;
            n.st = SMS_READ;
          end else if (r.mode == `SMS_M_JUMP || r.mode == `SMS_M_JUMPSNAP) begin
            n.mv = {1'b1, 1'b1, SMS_VEL_PRIMARY, active_axes, jump_distance};  // R11 R12
          end
        end else if (r.keyl[`SMS_K_THIRD]) begin
          n.keyl[`SMS_K_THIRD] = 1'b0;
          if (r.mode == `SMS_M_EXT && r.count != 5'h00) begin
            n.mv = {1'b1, 1'b0, SMS_VEL_SECONDARY, 4'hf, approach_waypoint};  // R4 R19
            n.after = SMS_NX_FIRST;
            n.arm_pend = 1'b1;
            n.st = SMS_WAIT;
          end
        end else if (r.keyl[`SMS_K_FOURTH]) begin
          n.keyl[`SMS_K_FOURTH] = 1'b0;
          if (r.mode == `SMS_M_EXT) begin
            n.mv = {1'b1, 1'b0, SMS_VEL_SECONDARY, 4'hf, approach_waypoint};  // R4 R19
            n.after = SMS_NX_HOME;
            n.armed = 1'b0;  // R21
            n.arm_pend = 1'b0;
            n.st = SMS_WAIT;
          end
        end
      end
      // read address set, data on next cycle
      SMS_READ: begin
        n.st = SMS_LOAD;
      end
      // issue list entry, only masked axes travel
      SMS_LOAD: begin
        n.mv = {1'b1, 1'b0, r.vel, rdata.mask, rdata.pos};  // R17
        n.st = SMS_WAIT;
      end
      // wait for the planners, then continue the sequence
      SMS_WAIT: begin
        if (motion_done) begin
          case (r.after)
            SMS_NX_HOME: begin
              n.mv = {1'b1, 1'b0, SMS_VEL_SECONDARY, 4'hf, home_pos};  // R20
              n.after = SMS_NX_NONE;
            end
            SMS_NX_FIRST: begin
              n.idx = 4'h0;  // R20
              n.raddr = 4'h0;
              n.vel = SMS_VEL_PRIMARY;
              n.after = SMS_NX_NONE;
              n.st = SMS_READ;
            end
            SMS_NX_PATH: begin
              if ({1'b0, r.idx} + 5'h01 < r.count) begin
                n.idx = r.idx + 4'h1;  // R5
                n.raddr = n.idx;
                n.st = SMS_READ;
              end else begin
                n.st = SMS_IDLE;
              end
            end
            SMS_NX_AUTO: begin
              n.dcnt = '0;
              n.st = SMS_DELAY;
            end
            default: begin
              n.st = SMS_IDLE;
              if (r.arm_pend) begin
                n.armed = 1'b1;  // R21
                n.arm_pend = 1'b0;
              end
            end
          endcase
        end
      end
      // dwell between auto positions, pause holds here
      SMS_DELAY: begin
        if (r.dcnt < delay_cycles) begin
          n.dcnt = r.dcnt + 32'h1;  // R9
        end else if (r.back) begin
          n.back = 1'b0;  // R22
          n.idx = wrap_back(r.idx, r.count);
          n.raddr = n.idx;
          n.st = SMS_READ;
        end else if (!r.paused) begin
          n.idx = wrap_fwd(r.idx, r.count);  // R9
          n.raddr = n.idx;
          n.st = SMS_READ;
        end
      end
      default: begin
        n.st = SMS_IDLE;
      end
    endcase
    // mode 7 home key overrides any running sequence
    if (r.mode == `SMS_M_AUTO && !mode_wr && kin[`SMS_K_BACK]) begin
      n.keyl[`SMS_K_BACK] = 1'b0;
      n.mv = {1'b1, 1'b0, SMS_VEL_SECONDARY, 4'hf, approach_waypoint};  // R22 R19
      n.after = SMS_NX_HOME;
      n.paused = 1'b0;
      n.back = 1'b0;
      n.st = SMS_WAIT;
    end
    n.hold = n.pending ? trigger_axis_assign : 4'h0;  // R8
    n.busy = (n.st != SMS_IDLE);
  end
  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: SMS_IDLE, after: SMS_NX_NONE, vel: SMS_VEL_PRIMARY,
             mode: `SMS_MODE_RST, default: '0};  // R1
    end else if (ce) begin
      r <= n;
    end
  end
  // outputs straight from the control registers
  assign mode           = r.mode;
  assign mode_err       = r.mode_err;
  assign move           = r.mv;
  assign analog_capture = r.analog;
  assign list_count     = r.count;
  assign hold_axes      = r.hold;
  assign release_pulse  = r.release_p;
  assign follow_pos     = r.follow;
  assign follow_valid   = r.follow_vld;
  assign busy           = r.busy;
endmodule : sms_sequencer
`default_nettype wire

// ==== sms_chk_sva.sv ====
// port checker of the snapshot mode sequencer
`timescale 1ns/100ps
`default_nettype none
module sms_chk
  import sms_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       ce,
  input wire logic       mode_wr,
  input wire logic [3:0] mode_wdata,
  input wire logic       global_enable,
  input wire logic [3:0] keys,
  input wire logic       cmd_req,
  input wire logic [3:0] trigger_axis_assign,
  input wire sms_axes_t  approach_waypoint,
  input wire sms_axes_t  jump_distance,
  input wire logic [3:0] mode,
  input wire logic       mode_err,
  input wire sms_move_t  move,
  input wire logic [4:0] list_count,
  input wire logic [3:0] hold_axes,
  input wire logic       release_pulse,
  input wire logic       busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ====================
  // idle jump-mode primary key, then relative move
  sequence s_jump_req;
    ce && !mode_wr && global_enable && !busy && mode == `SMS_M_JUMP && keys == 4'h2;
  endsequence
  sequence s_jump_mv;
    ##[1:6] (move.valid && move.rel && move.pos == jump_distance);
  endsequence
  AST_JUMP: assert property (s_jump_req |-> s_jump_mv)
    else $error("no jump");
  AST_MODE_OK: assert property (ce && mode_wr && mode_wdata <= `SMS_MODE_MAX
    |=> mode == $past(mode_wdata) && !mode_err) else $error("mode not taken");
  AST_MODE_REJ: assert property (ce && mode_wr && mode_wdata > `SMS_MODE_MAX
    |=> mode == $past(mode) && mode_err) else $error("bad mode taken");
  AST_MODE_HOLD: assert property (!mode_wr |=> mode == $past(mode))
    else $error("mode moved");
  AST_WP_VEL: assert property (move.valid && !move.rel && move.pos == approach_waypoint
    |-> move.vel == SMS_VEL_SECONDARY) else $error("waypoint speed");
  AST_CAPTURE: assert property (ce && !mode_wr && global_enable && mode == `SMS_M_CAPKEY
    && keys == 4'h2 && list_count < 5'h10 |-> ##[1:4] $changed(list_count))
    else $error("no capture");
  AST_HOLD_SET: assert property (ce && !mode_wr && global_enable && cmd_req
    && mode == `SMS_M_TRIG |=> hold_axes == $past(trigger_axis_assign)) else $error("hold");
  AST_RELEASE: assert property (release_pulse && !$past(cmd_req) |-> hold_axes == 4'h0
    && $past(hold_axes) != 4'h0) else $error("stray release");
  AST_MODE_CLR: assert property (ce && mode_wr && !cmd_req |=> hold_axes == 4'h0)
    else $error("wait not cleared");
endmodule : sms_chk
`default_nettype wire

// ==== sms_plan_model.sv ====
// axis planner model: arrival pulse a fixed time after a move
`timescale 1ns/100ps
`default_nettype none
module sms_plan_model
  import sms_pkg::*;
#(parameter int LAT = 4)
(
  input  wire logic      clk,
  input  wire logic      arst_n,
  input  wire sms_move_t move,
  output var  logic      motion_done
);
  int cnt; // cycles of travel left
  // count out travel, then pulse arrival for one cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      motion_done <= 1'b0;
    end else begin
      motion_done <= (cnt == 1);
      if (move.valid) cnt <= LAT;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule : sms_plan_model
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench of the snapshot mode sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sms_pkg::*;
  logic clk = 0, arst_n = 0, ce = 1, mode_wr = 0, global_enable = 1, snap_in = 1;
  logic input_polarity_select = 0, inject_valid = 0, trigger_out_evt = 0, cmd_req = 0;
  logic handheld_enable = 1, list_wr = 0, list_clear = 0, got;
  logic [3:0] mode_wdata = 0, keys = 0, trigger_axis_assign = 0, active_axes = 4'hf;
  logic [3:0] list_widx = 1, em = 0, mode, hold_axes;
  logic [2:0] inject_value = 0;
  logic [11:0] aux_analog_input = 0, analog_capture;
  logic [31:0] delay_cycles = 3, seed = 32'h37;
  sms_axes_t cur_pos = 0, approach_waypoint = 0, home_pos = 0, jump_distance = 0;
  sms_entry_t list_wdata = 0, el [3];
  sms_move_t move, m;
  logic mode_err, release_pulse, follow_valid, busy, motion_done;
  logic [4:0] list_count;
  sms_pos_t follow_pos;
  int error_cnt = 0, n_tests = 0;
  sms_sequencer uut (.*);
  sms_plan_model u_plan (.*);
  // ====================
  // helpers
  initial forever #2.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic sms_axes_t rax();
    return {rnd(), rnd(), rnd(), rnd()};
  endfunction : rax
  task automatic chk(input string nm, input logic [135:0] seen, input logic [135:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // one key for a cycle, by pin or by inject
  task automatic press(input int k, input logic inj);
    @(negedge clk);
    inject_value = 3'(k + 1);
    inject_valid = inj;
    keys[k] = !inj;
    @(negedge clk);
    keys = 4'h0;
    inject_valid = 1'b0;
  endtask : press
  task automatic setm(input logic [3:0] v);
    @(negedge clk);
    mode_wr = 1'b1;
    mode_wdata = v;
    @(negedge clk);
    mode_wr = 1'b0;
  endtask : setm
  task automatic getmv();
    m = '0;
    for (int i = 0; i < 40 && m.valid !== 1'b1; i++) begin
      @(negedge clk);
      if (move.valid === 1'b1) m = move;
    end
  endtask : getmv
  task automatic idle();
    for (int i = 0; i < 30 && busy !== 1'b0; i++) @(negedge clk);
    @(negedge clk);
  endtask : idle
  task automatic pulse_cmd();
    @(negedge clk);
    cmd_req = 1'b1;
    @(negedge clk);
    cmd_req = 1'b0;
  endtask : pulse_cmd
  task automatic watch_rel();
    got = 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      got |= release_pulse;
    end
  endtask : watch_rel
  // ====================
  // scenarios
  initial begin
    approach_waypoint = rax();
    home_pos = rax();
    jump_distance = rax();
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    chk("mode", {mode, mode_err}, 5'h0);
    for (int v = 15; v >= 0; v--) begin
      setm(4'(v));
      if (v <= 12) em = 4'(v);
      chk("mode", {mode, mode_err}, {em, v > 12});
    end
    for (int i = 0; i < 3; i++) begin
      cur_pos = rax();
      aux_analog_input = 12'(rnd());
      active_axes = 4'(rnd()) | 4'h1;
      el[i] = {active_axes, cur_pos};
      press(1, 0);
      repeat (3) @(negedge clk);
      chk("capture", {list_count, analog_capture}, {5'(i + 1), aux_analog_input});
    end
    el[1] = {4'h5, rax()};
    list_wr = 1'b1;
    list_wdata = el[1];
    @(negedge clk);
    list_wr = 1'b0;
    setm(1);
    for (int i = 1; i <= 3; i++) begin
      press(1, i == 3);
      getmv();
      chk("step", {m.valid, m.vel, m.mask, m.pos}, {1'b1, SMS_VEL_PRIMARY, el[i % 3]});
      idle();
    end
    setm(2);
    press(1, 0);
    getmv();
    chk("unarmed", m.valid, 1'b0);
    press(3, 0);
    getmv();
    chk("wp", {m.valid, m.vel, m.pos}, {1'b1, SMS_VEL_SECONDARY, approach_waypoint});
    getmv();
    chk("home", {m.valid, m.vel, m.pos}, {1'b1, SMS_VEL_SECONDARY, home_pos});
    idle();
    setm(9);
    press(1, 0);
    getmv();
    chk("jump", {m.valid, m.rel, m.pos}, {2'b11, jump_distance});
    idle();
    cur_pos.x = 32'h7fffffff;
    setm(11);
    getmv();
    chk("follow", {follow_valid, follow_pos}, {1'b1, el[2].pos.z});
    setm(6);
    trigger_axis_assign = 4'(rnd()) | 4'h8;
    pulse_cmd();
    chk("hold", hold_axes, trigger_axis_assign);
    snap_in = 1'b0;
    watch_rel();
    chk("release", {got, hold_axes}, 5'h10);
    pulse_cmd();
    snap_in = 1'b1;
    watch_rel();
    chk("no release", got, 1'b0);
    setm(6);
    chk("cleared", hold_axes, 4'h0);
    report_and_stop();
  end
  // hang guard
  initial begin
    #50000;
    error_cnt++;
    report_and_stop();
  end
endmodule : testbench
bind sms_sequencer sms_chk u_chk (.*);
`default_nettype wire
